// >>> core/card_clk_pkg.sv
// Contract
// R1: Gate bit low stops the card clock
// R2: Divisor changed only while gate is off
// R3: Keep frequency, stop with card clock low
// R4: Card removal clears the gate bit
// R5: Stable flag rises once oscillator settles
// R6: Software waits for stable before gating on
// R7: Oscillator halts while its enable is low
// R8: Registers stay accessible without oscillator
// R9: Oscillator starts as soon as enabled
// R10: Presence detection ignores oscillator enable
// R11: Four-bit field sets data timeout interval
// R12: Interval is base period times 2^(13+code)
// R13: Software disables timeout event before rewriting
// R14: Software programs timeout at initialisation
// R15: One-hot divisor, 80h /256 down to 00h
// R16: Highest set divisor bit wins
// R17: Stable flag clears when oscillator stops
package card_clk_pkg;

   // ==========================================================
   // Register bus shape
   localparam int ADDR_W = 8;  // Byte address width
   localparam int DATA_W = 16; // Register data width

   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_CLOCK    = 8'h2c; // clock_gate_control
   localparam logic [7:0] OFS_TIMEOUT  = 8'h2e; // data_timeout_setting
   localparam logic [7:0] OFS_EVT_STAT = 8'h40; // Sticky event status
   localparam logic [7:0] OFS_EVT_MASK = 8'h42; // Event interrupt mask
   localparam logic [7:0] OFS_AUX      = 8'h44; // Timeout enable, state

   // ==========================================================
   // Field positions
   localparam int CC_INT_EN_BIT  = 0;  // Internal clock enable
   localparam int CC_STABLE_BIT  = 1;  // Internal clock stable, RO
   localparam int CC_GATE_BIT    = 2;  // card_clock_gate_on
   localparam int CC_DIV_LSB     = 8;  // card_clock_divisor low bit
   localparam int DIV_W          = 8;  // Divisor field width
   localparam int TO_W           = 4;  // Timeout code width
   localparam int AUX_TO_EN_BIT  = 0;  // Timeout event enable
   localparam int AUX_PRES_BIT   = 8;  // Card present, RO
   localparam int AUX_RUN_BIT    = 9;  // Card clock running, RO

   // ==========================================================
   // Event bits
   localparam int EVT_W       = 4; // Number of events
   localparam int EVT_INSERT  = 0; // Card inserted
   localparam int EVT_REMOVE  = 1; // Card removed
   localparam int EVT_STABLE  = 2; // Internal clock became stable
   localparam int EVT_TIMEOUT = 3; // Data line timeout

   // ==========================================================
   // Reset values and timing
   localparam logic [DIV_W-1:0] DIV_RST      = 8'h00; // Undivided
   localparam logic [TO_W-1:0]  TO_RST       = 4'h0;  // Shortest
   localparam logic [TO_W-1:0]  TO_CODE_MAX  = 4'he;  // Largest legal
   localparam int               TO_EXP_BASE  = 13;    // 2^13 at code 0
   localparam int               TO_CNT_W     = 28;    // Holds 2^27
   localparam int               SETTLE_DEF   = 16;    // sys_clk cycles
   localparam int               SETTLE_W     = 16;    // Settle counter
   localparam int               HALF_W       = 9;     // Up to 256

   // Oscillator states, one-hot
   typedef enum logic [2:0] {
      OSC_OFF    = 3'b001,
      OSC_SETTLE = 3'b010,
      OSC_STABLE = 3'b100
   } osc_state_e;

endpackage : card_clk_pkg

// >>> core/card_clock_ctrl.sv
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module card_clock_ctrl
   import card_clk_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_DEF,  // Oscillator settle time
   parameter int TO_BASE_EXP   = TO_EXP_BASE  // Exponent at code 0
) (
   input  wire logic              sys_clk,         // 50 MHz clock
   input  wire logic              reset_n,         // Async reset
   input  wire logic [ADDR_W-1:0] addr,            // Register address
   input  wire logic [DATA_W-1:0] wr_data,         // Write data
   input  wire logic              wr_en,           // Write strobe
   input  wire logic              rd_en,           // Read strobe
   output logic      [DATA_W-1:0] rd_data,         // Read data, next cycle
   input  wire logic              card_present,    // Card detect level
   input  wire logic              data_wait,       // Waiting on data line
   input  wire logic              timeout_base_clock, // Timeout base
   output logic                   card_clock_out,  // Clock to the card
   output logic                   osc_enable,      // Internal osc run
   output logic                   data_timeout,    // Timeout pulse
   output logic                   irq              // Level interrupt
);

   // ==========================================================
   // Overview
   // All control fields live in one state record. One
   // combinational process works out the next record and one
   // clocked process stores it.
   // The internal oscillator is stood in for by a settle
   // counter; osc_enable asks the clock source to run.
   // The card clock is made by counting host cycles, so its
   // fastest rate is half of sys_clk.
   // Timeout base edges are found by sampling, so that clock
   // must run no faster than half of sys_clk.

   // ==========================================================
   // State record
   // Every register of the block lives here, so reset and the
   // clocked update stay in one place and cannot drift apart
   typedef struct packed {
      osc_state_e           osc;          // Oscillator state
      logic [SETTLE_W-1:0]  settle_cnt;   // Settle counter
      logic                 int_en;       // Internal clock enable
      logic                 gate_on;      // card_clock_gate_on
      logic [DIV_W-1:0]     divisor;      // card_clock_divisor
      logic [DIV_W-1:0]     act_div;      // Divisor in use
      logic [HALF_W-1:0]    half_cnt;     // Half period counter
      logic                 card_clk;     // Card clock level
      logic [TO_W-1:0]      to_code;      // Timeout code
      logic                 to_en;        // Timeout event enable
      logic [TO_CNT_W-1:0]  to_cnt;       // Timeout edge counter
      logic                 to_fired;     // Timeout already seen
      logic                 to_pulse;     // Timeout output pulse
      logic                 tm_prev;      // Previous base clock level
      logic                 present_prev; // Previous card detect
      logic [EVT_W-1:0]     evt_stat;     // Sticky events
      logic [EVT_W-1:0]     evt_mask;     // Interrupt mask
      logic [DATA_W-1:0]    rd_data;      // Read data holding
   } ctl_s;

   ctl_s ctl_reg;  // Registered state
   ctl_s ctl_next; // Next state

   // Last settle count before the oscillator is trusted; the
   // stable state is entered on the edge after this count
   localparam logic [SETTLE_W-1:0] SETTLE_LAST =
      SETTLE_W'(SETTLE_CYCLES - 1);

   // ==========================================================
   // Helpers

   // Half period in sys_clk cycles; highest set bit wins
   // 00h gives one cycle, so the fastest card clock is half
   // the host clock; a multi-bit setting is not refused
   function automatic logic [HALF_W-1:0] half_period(
      input logic [DIV_W-1:0] div);
      logic [HALF_W-1:0] hp;
      hp = HALF_W'(1);                              // R15
      for (int i = 0; i < DIV_W; i++) begin
         if (div[i]) begin
            hp = HALF_W'(1) << (i + 1);             // R16
         end
      end
      return hp;
   endfunction : half_period

   // Last count before timeout; reserved code acts as the largest
   // Clamping the reserved code keeps a bad write from asking
   // for an interval longer than the counter can hold
   function automatic logic [TO_CNT_W-1:0] to_last(
      input logic [TO_W-1:0] code);
      logic [TO_W-1:0] c;
      c = (code > TO_CODE_MAX) ? TO_CODE_MAX : code;
      return (TO_CNT_W'(1) << (TO_BASE_EXP + int'(c)))
             - TO_CNT_W'(1);                        // R12
   endfunction : to_last

   // ==========================================================
   // Next state
   // Worked out from the registered record and this cycle's
   // inputs; the defaults below hold every field unchanged except to_pulse, which clears
   always_comb begin
      logic              stable;  // Oscillator settled
      logic              run_ok;  // Card clock may run
      logic              tick;    // Timeout base rising edge
      logic [EVT_W-1:0]  set_ev;  // Events this cycle
      logic [EVT_W-1:0]  clr_ev;  // Software clears this cycle
      stable   = 1'b0;
      run_ok   = 1'b0;
      tick     = 1'b0;
      set_ev   = '0;
      clr_ev   = '0;
      ctl_next = ctl_reg;
      ctl_next.to_pulse = 1'b0;

      // Register writes; always served, oscillator or not
      // The bus runs on sys_clk, never on the oscillator, so a
      // halted oscillator cannot lock software out
      if (wr_en) begin                              // R8
         case (addr)
            OFS_CLOCK: begin
               // Stable bit is read-only and ignored here
               ctl_next.int_en  = wr_data[CC_INT_EN_BIT];
               ctl_next.gate_on = wr_data[CC_GATE_BIT];
               ctl_next.divisor = wr_data[CC_DIV_LSB +: DIV_W];
            end
            OFS_TIMEOUT: begin
               // Restart the count under the new interval
               ctl_next.to_code = wr_data[TO_W-1:0]; // R11
               ctl_next.to_cnt  = '0;
            end
            OFS_EVT_STAT: begin
               // Write one to clear; zeros leave bits alone
               clr_ev = wr_data[EVT_W-1:0];
            end
            OFS_EVT_MASK: begin
               // Mask only gates irq; status still records
               ctl_next.evt_mask = wr_data[EVT_W-1:0];
            end
            OFS_AUX: begin
               // Other aux bits are status only
               ctl_next.to_en = wr_data[AUX_TO_EN_BIT];
            end
            default: begin
               // Unmapped writes are dropped
            end
         endcase
      end

      // No card, no clock gate; a write of one is overridden
      // Removal thus stops the card clock even if software is
      // slow to react; a high phase in flight still finishes
      if (!card_present) begin
         ctl_next.gate_on = 1'b0;                   // R4
      end

      // Oscillator control
      // The settle counter stands in for the start-up time of
      // the real oscillator; it only runs while enabled
      case (ctl_reg.osc)
         OSC_OFF: begin
            // Halted: counter parked at zero
            ctl_next.settle_cnt = '0;
            if (ctl_reg.int_en) begin
               ctl_next.osc = OSC_SETTLE;           // R9
            end
         end
         OSC_SETTLE: begin
            // Dropping the enable abandons the start-up at once
            if (!ctl_reg.int_en) begin
               ctl_next.osc = OSC_OFF;              // R7
            end else if (ctl_reg.settle_cnt == SETTLE_LAST) begin
               ctl_next.osc = OSC_STABLE;           // R5
               set_ev[EVT_STABLE] = 1'b1;
            end else begin
               ctl_next.settle_cnt = ctl_reg.settle_cnt + 1'b1;
            end
         end
         OSC_STABLE: begin
            // Runs until software drops the enable
            if (!ctl_reg.int_en) begin
               ctl_next.osc = OSC_OFF;              // R17
            end
         end
         default: begin
            // Illegal code: fall back to halted
            ctl_next.osc = OSC_OFF;
         end
      endcase
      stable = (ctl_reg.osc == OSC_STABLE);

      // Card clock divider; a high phase always runs to its end
      // Cutting a high phase short would hand the card a runt
      // pulse, so the gate only takes effect while it is low
      run_ok = ctl_reg.gate_on & stable;            // R6
      if (ctl_reg.card_clk || run_ok) begin
         if (ctl_reg.half_cnt ==
             half_period(ctl_reg.act_div) - HALF_W'(1)) begin
            ctl_next.half_cnt = '0;
            if (ctl_reg.card_clk) begin
               ctl_next.card_clk = 1'b0;            // R3
            end else begin
               ctl_next.card_clk = 1'b1;
            end
         end else begin
            ctl_next.half_cnt = ctl_reg.half_cnt + 1'b1;
         end
      end else begin
         // Stopped low: only now may a new divisor take hold
         ctl_next.half_cnt = '0;                    // R1
         ctl_next.act_div  = ctl_reg.divisor;       // R2
      end

      // Data line timeout on timeout base clock edges
      // The base clock is sampled by sys_clk, so it must run no
      // faster than half the host rate for no edge to be lost
      ctl_next.tm_prev = timeout_base_clock;
      tick = timeout_base_clock & ~ctl_reg.tm_prev;
      if (!data_wait) begin
         // Nothing pending: hold the counter at zero
         ctl_next.to_cnt   = '0;
         ctl_next.to_fired = 1'b0;
      end else if (wr_en && addr == OFS_TIMEOUT) begin
         // A new interval restarts from zero, even on a base edge
         ctl_next.to_cnt   = '0;
         ctl_next.to_fired = 1'b0;
      end else if (tick && !ctl_reg.to_fired) begin
         if (ctl_reg.to_cnt == to_last(ctl_reg.to_code)) begin
            ctl_next.to_fired = 1'b1;               // R12
            // One pulse per wait; to_fired holds off the rest
            ctl_next.to_pulse = 1'b1;
            set_ev[EVT_TIMEOUT] = ctl_reg.to_en;    // R13
         end else begin
            ctl_next.to_cnt = ctl_reg.to_cnt + 1'b1;
         end
      end

      // Card detect runs regardless of the oscillator
      ctl_next.present_prev = card_present;         // R10
      set_ev[EVT_INSERT] = card_present & ~ctl_reg.present_prev;
      set_ev[EVT_REMOVE] = ~card_present & ctl_reg.present_prev;

      // Sticky status; a new event beats a clear
      // so an event in the clearing cycle is never lost
      ctl_next.evt_stat = (ctl_reg.evt_stat & ~clr_ev) | set_ev;

      // Read data stands only in the cycle after the strobe
      // Zero at other times lets read buses be merged by OR
      ctl_next.rd_data = '0;
      if (rd_en) begin
         case (addr)
            OFS_CLOCK: begin
               ctl_next.rd_data[CC_DIV_LSB +: DIV_W] = ctl_reg.divisor;
               ctl_next.rd_data[CC_GATE_BIT]   = ctl_reg.gate_on;
               ctl_next.rd_data[CC_STABLE_BIT] = stable;
               ctl_next.rd_data[CC_INT_EN_BIT] = ctl_reg.int_en;
            end
            OFS_TIMEOUT: begin
               ctl_next.rd_data[TO_W-1:0] = ctl_reg.to_code;
            end
            OFS_EVT_STAT: begin
               ctl_next.rd_data[EVT_W-1:0] = ctl_reg.evt_stat;
            end
            OFS_EVT_MASK: begin
               ctl_next.rd_data[EVT_W-1:0] = ctl_reg.evt_mask;
            end
            OFS_AUX: begin
               // Presence is live, whatever the oscillator does
               ctl_next.rd_data[AUX_TO_EN_BIT] = ctl_reg.to_en;
               ctl_next.rd_data[AUX_PRES_BIT]  = card_present;
               ctl_next.rd_data[AUX_RUN_BIT]   = run_ok;
            end
            default: begin
               // Unmapped reads return zero
            end
         endcase
      end
   end

   // ==========================================================
   // State register
   // Reset loads constants only; the enum field needs its own
   // value since an all-zero code is not a legal state
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_reg              <= '0;
         ctl_reg.osc          <= OSC_OFF;
         ctl_reg.divisor      <= DIV_RST;
         ctl_reg.act_div      <= DIV_RST;
         ctl_reg.to_code      <= TO_RST;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // ==========================================================
   // Outputs, all from flip-flops except the interrupt level and osc_enable
   // osc_enable is a plain decode of the one-hot state register
   assign rd_data        = ctl_reg.rd_data;
   assign card_clock_out = ctl_reg.card_clk;
   assign osc_enable     = (ctl_reg.osc != OSC_OFF);
   assign data_timeout   = ctl_reg.to_pulse;
   assign irq            = |(ctl_reg.evt_stat & ctl_reg.evt_mask);

endmodule : card_clock_ctrl

// >>> testbench/card_clock_ctrl_chk.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker for the card clock block
module card_clock_ctrl_chk
   import card_clk_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_DEF,  // Oscillator settle time
   parameter int TO_BASE_EXP   = TO_EXP_BASE  // Exponent at code 0
) (
   input wire logic              sys_clk,            // Clock
   input wire logic              reset_n,            // Async reset
   input wire logic [ADDR_W-1:0] addr,               // Address
   input wire logic [DATA_W-1:0] wr_data,            // Write data
   input wire logic              wr_en,              // Write strobe
   input wire logic              rd_en,              // Read strobe
   input wire logic [DATA_W-1:0] rd_data,            // Read data
   input wire logic              card_present,       // Card detect
   input wire logic              data_wait,          // Data pending
   input wire logic              timeout_base_clock, // Timeout base
   input wire logic              card_clock_out,     // Card clock
   input wire logic              osc_enable,         // Oscillator run
   input wire logic              data_timeout,       // Timeout pulse
   input wire logic              irq                 // Interrupt
);
   // Base edges need two cycles each, so this is the fastest timeout
   localparam int TO_MIN = (2 << TO_BASE_EXP) - 3;
   logic [31:0] run_cnt;  // Cycles of unbroken waiting

   // Restart the count wherever the block must restart its own
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         run_cnt <= '0;
      end else if (!data_wait || (wr_en && addr == OFS_TIMEOUT)) begin
         run_cnt <= '0;
      end else begin
         run_cnt <= run_cnt + 32'h1;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // The enable bit lands at the write edge, the state one edge on
   osc_start_a: assert property (wr_en && addr == OFS_CLOCK
      && wr_data[CC_INT_EN_BIT] |=> ##1 osc_enable)
      else $error("osc no start");
   osc_halt_a: assert property (wr_en && addr == OFS_CLOCK
      && !wr_data[CC_INT_EN_BIT] |=> ##1 !osc_enable)
      else $error("osc runs");
   clk_needs_osc_a: assert property ($rose(card_clock_out)
      |-> $past(osc_enable)) else $error("clock without oscillator");
   absent_no_rise_a: assert property (!card_present[*3]
      |-> !$rose(card_clock_out)) else $error("clock with no card");
   read_idle_a: assert property (!$past(rd_en)
      |-> rd_data == '0) else $error("read data outside slot");
   mask_off_a: assert property (wr_en && addr == OFS_EVT_MASK
      && wr_data == '0 |=> !irq) else $error("irq while masked");
   pulse_once_a: assert property (data_timeout
      |=> !data_timeout) else $error("timeout pulse too long");
   interval_min_a: assert property (data_timeout
      |-> run_cnt >= TO_MIN) else $error("timeout too early");
endmodule : card_clock_ctrl_chk

bind card_clock_ctrl card_clock_ctrl_chk #(
   .SETTLE_CYCLES(SETTLE_CYCLES), .TO_BASE_EXP(TO_BASE_EXP)) chk_i (
   .sys_clk(sys_clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
   .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
   .card_present(card_present), .data_wait(data_wait),
   .timeout_base_clock(timeout_base_clock),
   .card_clock_out(card_clock_out), .osc_enable(osc_enable),
   .data_timeout(data_timeout), .irq(irq));

// >>> testbench/card_model.sv
`timescale 1ns/100ps
// ==========================================================
// Card seat: detect level and card clock period meter
module card_model (
   input  wire logic sys_clk,        // Host clock
   input  wire logic card_clock_out, // Clock from the host
   input  wire logic insert,         // Bench seats the card
   output logic      card_present,   // Detect level
   output int        period,         // Cycles between last rises
   output int        rises           // Rising edges seen
);
   logic last;  // Previous card clock level
   int   gap;   // Cycles since last rise

   initial begin
      card_present = 1'b0;
      period = 0;
      rises = 0;
      last = 1'b0;
      gap = 0;
   end

   // Detect changes only at a host edge, like a real switch sampled
   always @(posedge sys_clk) begin
      card_present <= insert;
      last <= card_clock_out;
      gap <= gap + 1;
      if (card_clock_out && !last) begin
         period <= gap;
         gap <= 1;
         rises <= rises + 1;
      end
   end
endmodule : card_model

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb;
   import card_clk_pkg::*;
   localparam int SETTLE = 4;  // Short oscillator settle
   localparam int TEXP   = 2;  // Short timeout exponent
   logic        sys_clk, reset_n, wr_en, rd_en, insert, data_wait, tbc;
   logic        cko, osc, dto, irq, pres;
   logic [7:0]  addr, dv;
   logic [15:0] wr_data, rd_data, d;
   logic [3:0]  c;
   int          period, rises, bad_count, n_checks, cyc, seed, r0, n;
   logic [7:0]  offs [6] = '{8'h2c, 8'h2e, 8'h40, 8'h42, 8'h44, 8'h10};
   logic [7:0]  divs [5] = '{8'h00, 8'h01, 8'h06, 8'h80, 8'h00};

   card_clock_ctrl #(.SETTLE_CYCLES(SETTLE), .TO_BASE_EXP(TEXP)) DUT (
      .sys_clk(sys_clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .card_present(pres),
      .data_wait(data_wait), .timeout_base_clock(tbc),
      .card_clock_out(cko), .osc_enable(osc), .data_timeout(dto), .irq(irq));
   card_model CARD (.sys_clk(sys_clk), .card_clock_out(cko),
      .insert(insert), .card_present(pres), .period(period), .rises(rises));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Base clock at half rate; hang guard
   always @(posedge sys_clk) begin
      tbc <= ~tbc;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         results();
      end
   end

   task wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask : wr

   // Data shows only in the slot after the strobe
   task rd(input logic [7:0] a);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      @(negedge sys_clk);
      d = rd_data;
   endtask : rd

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // Card clock half period in host cycles, top set bit wins
   function int half(input logic [7:0] v);
      half = 1;
      for (int k = 0; k < 8; k++) if (v[k]) half = 2 << k;
   endfunction : half

   task results;
      $display("Counts: %0d checks, %0d mismatches", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results

   initial begin
      {reset_n, wr_en, rd_en, insert, data_wait, tbc} = 6'h0;
      {addr, wr_data, bad_count, n_checks, cyc} = '0;
      seed = 32'he94d;
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      foreach (offs[i]) begin
         rd(offs[i]);
         chk(d, 16'h0);
      end
      $display("reset values done");
      insert <= 1'b1;
      wr(OFS_CLOCK, 16'h0001);
      rd(OFS_CLOCK);
      chk(16'(osc), 16'h1);
      repeat (SETTLE + 2) @(posedge sys_clk);
      rd(OFS_CLOCK);
      chk(16'(d[1]), 16'h1);
      wr(OFS_CLOCK, 16'h0000);
      wr(OFS_TIMEOUT, 16'h0003);
      rd(OFS_CLOCK);
      chk(d, 16'h0);
      chk(16'(osc), 16'h0);
      rd(OFS_TIMEOUT);
      chk(d, 16'h0003);
      wr(OFS_CLOCK, 16'h0001);
      repeat (SETTLE + 4) @(posedge sys_clk);
      $display("oscillator done");
      divs[4] = 8'($random(seed));
      foreach (divs[i]) begin
         dv = divs[i];
         wr(OFS_CLOCK, {dv, 8'h01});
         wr(OFS_CLOCK, {dv, 8'h05});
         repeat (6 * half(dv) + 8) @(posedge sys_clk);
         chk(16'(period), 16'(2 * half(dv)));
         wr(OFS_CLOCK, {dv, 8'h01});
         repeat (half(dv) + 4) @(negedge sys_clk);
         r0 = rises;
         chk(16'(cko), 16'h0);
         repeat (2 * half(dv) + 4) @(posedge sys_clk);
         chk(16'(rises - r0), 16'h0);
      end
      $display("divisor done");
      wr(OFS_CLOCK, 16'h0105);
      wr(OFS_EVT_MASK, 16'h0002);
      insert <= 1'b0;
      repeat (10) @(posedge sys_clk);
      rd(OFS_CLOCK);
      chk(16'(d[2]), 16'h0);
      chk(16'(irq), 16'h1);
      wr(OFS_EVT_STAT, 16'h0002);
      rd(OFS_EVT_STAT);
      chk(16'(d[1]), 16'h0);
      chk(16'(irq), 16'h0);
      wr(OFS_EVT_MASK, 16'h0000);
      wr(OFS_CLOCK, 16'h0000);
      insert <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(OFS_AUX);
      chk(16'(d[8]), 16'h1);
      $display("card detect done");
      for (int i = 0; i < 4; i++) begin
         c = (i < 3) ? 4'(i) : 4'($random(seed)) & 4'h3;
         wr(OFS_AUX, 16'h0000);
         wr(OFS_TIMEOUT, 16'(c));
         wr(OFS_AUX, 16'h0001);
         data_wait <= 1'b1;
         n = 0;
         while (dto !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
         end
         @(posedge sys_clk);
         data_wait <= 1'b0;
         chk(16'(n >= (2 << (TEXP + c)) - 2 && n <= (2 << (TEXP + c)) + 4),
             16'h1);
         rd(OFS_EVT_STAT);
         chk(16'(d[3]), 16'h1);
         wr(OFS_EVT_STAT, 16'h0008);
      end
      $display("timeout done");
      results();
   end
endmodule : tb
